// ### hw/vichc_pkg.sv
// Purpose: Constants and carriers for the virtual interrupt interface hyp control block
// Assumes: Registers reached by system-register select codes on the core's register port
package vichc_pkg;
  // Register select codes
  localparam logic [3:0] SEL_VIF_CTRL = 4'h0;
  localparam logic [3:0] SEL_AP_G0 = 4'h1;
  localparam logic [3:0] SEL_AP_G1 = 4'h2;
  localparam logic [3:0] SEL_HCR = 4'h3;
  localparam logic [3:0] SEL_VMCR = 4'h4;
  localparam logic [3:0] SEL_BP_G0 = 4'h5;
  localparam logic [3:0] SEL_BP_G1 = 4'h6;
  localparam logic [3:0] SEL_PMR = 4'h7;
  // Field positions
  localparam int CTL_SPLIT = 1;
  localparam int CTL_SHARED = 0;
  localparam int HCR_CNT_LSB = 27;
  localparam int HCR_DEACTIVATE_WRITE_TRAP = 14;
  localparam int HCR_SYS_ERROR_TRAP = 13;
  localparam int HCR_GRP1_ACCESS_TRAP = 12;
  localparam int HCR_GRP0_ACCESS_TRAP = 11;
  localparam int HCR_TC = 10;
  localparam int HCR_G1D = 7;
  localparam int HCR_G1E = 6;
  localparam int HCR_G0D = 5;
  localparam int HCR_G0E = 4;
  localparam int HCR_NP = 3;
  localparam int HCR_LRENP = 2;
  localparam int HCR_UNDER = 1;
  localparam int HCR_EN = 0;
  localparam int VM_PMR_LSB = 24;
  localparam int VM_BP0_LSB = 21;
  localparam int VM_BP1_LSB = 18;
  localparam int VM_SPLIT = 9;
  localparam int VM_ENG1 = 1;
  localparam int VM_ENG0 = 0;
  // Reset values and limits
  localparam logic [31:0] AP_RESET = 32'h0000_0000;
  localparam logic [2:0] BP0_MIN = 3'h2;
  localparam logic [2:0] BP1_MIN = 3'h3;
  localparam logic [2:0] BP_MAX = 3'h7;
  localparam logic [7:0] PMR_RESET = 8'h00;
  localparam int NUM_LR = 4;

  // Register access from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] sel;
    logic [31:0] wdata;
  } vichc_req_s;

  // Guest-kernel access classification for trapping
  typedef struct packed {
    logic valid;
    logic is_write;
    logic guest_ns_kernel;
    logic grp0_reg;
    logic grp1_reg;
    logic common_reg;
    logic deact_reg;
  } vichc_guest_s;

  // Trap and behaviour outputs
  typedef struct packed {
    logic trap;
    logic eoi_deactivates;
    logic deact_reg_active;
    logic [2:0] preempt_bp_g0;
    logic [2:0] preempt_bp_g1;
  } vichc_ctl_s;
endpackage

// ### hw/vichc_top.sv
// Purpose: Hypervisor control, active priorities and VM state view of a virtual interrupt interface
// Assumes: Single core clock; list register status and EOI events come from the list register logic
// Notes: Reads return data one cycle after the request
`timescale 1ns/10ps
module vichc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire vichc_pkg::vichc_req_s req,
  output logic [31:0] rdata,
  output logic rvalid,
  // Guest access check
  input wire vichc_pkg::vichc_guest_s guest,
  output vichc_pkg::vichc_ctl_s ctl,
  // List register status and deactivation bookkeeping
  input wire logic [vichc_pkg::NUM_LR-1:0] lr_pending,
  input wire logic [vichc_pkg::NUM_LR-1:0] lr_valid,
  input wire logic eoi_no_entry,
  input wire logic deact_done,
  // Maintenance interrupt
  output logic maint_irq
);
  import vichc_pkg::*;

  logic split_eoi_select;
  logic shared_binpoint_select;
  logic [31:0] ap_g0;
  logic [31:0] ap_g1;
  logic [4:0] pending_deactivate_count;
  logic deactivate_write_trap;
  logic grp1_access_trap;
  logic grp0_access_trap;
  logic common_reg_trap;
  logic g1_off_maint_en;
  logic g1_on_maint_en;
  logic g0_off_maint_en;
  logic g0_on_maint_en;
  logic none_pending_maint_en;
  logic entry_absent_maint_en;
  logic underflow_maint_en;
  logic hyp_enable;
  logic [7:0] guest_prio_mask;
  logic [2:0] guest_binpoint_g0;
  logic [2:0] guest_binpoint_g1;
  logic guest_g1_enable;
  logic guest_g0_enable;
  logic wr;
  logic [31:0] next_rdata;
  logic [2:0] bp1_view;

  assign wr = req.valid && req.write;

  // Clamp a requested binary point to the group minimum
  function automatic logic [2:0] clamp_bp(input logic [2:0] v, input logic [2:0] vmin);
    clamp_bp = (v < vmin) ? vmin : v;
  endfunction

  // Group 1 view while shared: group 0 plus one, saturated
  assign bp1_view = shared_binpoint_select ?
    ((guest_binpoint_g0 == BP_MAX) ? BP_MAX : 3'(guest_binpoint_g0 + 3'h1)) : guest_binpoint_g1;

  // Split-EOI bit, written from the guest control or the VM view
  always_ff @(posedge mclk) begin
    if (rst) begin
      split_eoi_select <= 1'b0;
    end else if (wr && req.sel == SEL_VIF_CTRL) begin
      split_eoi_select <= req.wdata[CTL_SPLIT];
    end else if (wr && req.sel == SEL_VMCR) begin
      split_eoi_select <= req.wdata[VM_SPLIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shared_binpoint_select <= 1'b0;
    end else if (wr && req.sel == SEL_VIF_CTRL) begin
      shared_binpoint_select <= req.wdata[CTL_SHARED];
    end
  end

  // Active priority bitmaps
  always_ff @(posedge mclk) begin
    if (rst) begin
      ap_g0 <= AP_RESET;
      ap_g1 <= AP_RESET;
    end else if (wr && req.sel == SEL_AP_G0) begin
      ap_g0 <= req.wdata;
    end else if (wr && req.sel == SEL_AP_G1) begin
      ap_g1 <= req.wdata;
    end
  end

  // Hypervisor control fields
  always_ff @(posedge mclk) begin
    if (rst) begin
      deactivate_write_trap <= 1'b0;
      grp1_access_trap <= 1'b0;
      grp0_access_trap <= 1'b0;
      common_reg_trap <= 1'b0;
      g1_off_maint_en <= 1'b0;
      g1_on_maint_en <= 1'b0;
      g0_off_maint_en <= 1'b0;
      g0_on_maint_en <= 1'b0;
      none_pending_maint_en <= 1'b0;
      entry_absent_maint_en <= 1'b0;
      underflow_maint_en <= 1'b0;
      hyp_enable <= 1'b0;
    end else if (wr && req.sel == SEL_HCR) begin
      deactivate_write_trap <= req.wdata[HCR_DEACTIVATE_WRITE_TRAP];
      grp1_access_trap <= req.wdata[HCR_GRP1_ACCESS_TRAP];
      grp0_access_trap <= req.wdata[HCR_GRP0_ACCESS_TRAP];
      common_reg_trap <= req.wdata[HCR_TC];
      g1_off_maint_en <= req.wdata[HCR_G1D];
      g1_on_maint_en <= req.wdata[HCR_G1E];
      g0_off_maint_en <= req.wdata[HCR_G0D];
      g0_on_maint_en <= req.wdata[HCR_G0E];
      none_pending_maint_en <= req.wdata[HCR_NP];
      entry_absent_maint_en <= req.wdata[HCR_LRENP];
      underflow_maint_en <= req.wdata[HCR_UNDER];
      hyp_enable <= req.wdata[HCR_EN];
    end
  end

  // Outstanding deactivate count: hardware events win over software write
  always_ff @(posedge mclk) begin
    if (rst) begin
      pending_deactivate_count <= 5'h00;
    end else if (eoi_no_entry && !deact_done) begin
      pending_deactivate_count <= 5'(pending_deactivate_count + 5'h01);
    end else if (deact_done && !eoi_no_entry && pending_deactivate_count != 5'h00) begin
      pending_deactivate_count <= 5'(pending_deactivate_count - 5'h01);
    end else if (!eoi_no_entry && !deact_done && wr && req.sel == SEL_HCR) begin
      pending_deactivate_count <= req.wdata[31:HCR_CNT_LSB];
    end
  end

  // Guest view state: mask, binary points, group enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      guest_prio_mask <= PMR_RESET;
      guest_binpoint_g0 <= BP0_MIN;
      guest_binpoint_g1 <= BP1_MIN;
      guest_g1_enable <= 1'b0;
      guest_g0_enable <= 1'b0;
    end else if (wr && req.sel == SEL_VMCR) begin
      guest_prio_mask <= req.wdata[VM_PMR_LSB+:8];
      guest_binpoint_g0 <= clamp_bp(req.wdata[VM_BP0_LSB+:3], BP0_MIN);
      guest_binpoint_g1 <= clamp_bp(req.wdata[VM_BP1_LSB+:3], BP1_MIN);
      guest_g1_enable <= req.wdata[VM_ENG1];
      guest_g0_enable <= req.wdata[VM_ENG0];
    end else if (wr && req.sel == SEL_PMR) begin
      guest_prio_mask <= req.wdata[7:0];
    end else if (wr && req.sel == SEL_BP_G0) begin
      guest_binpoint_g0 <= clamp_bp(req.wdata[2:0], BP0_MIN);
    end else if (wr && req.sel == SEL_BP_G1 && !shared_binpoint_select) begin
      guest_binpoint_g1 <= clamp_bp(req.wdata[2:0], BP1_MIN);
    end
  end

  // Read mux; unmapped selects and reserved bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (req.sel)
      SEL_VIF_CTRL: begin
        next_rdata[CTL_SPLIT] = split_eoi_select;
        next_rdata[CTL_SHARED] = shared_binpoint_select;
      end
      SEL_AP_G0: next_rdata = ap_g0;
      SEL_AP_G1: next_rdata = ap_g1;
      SEL_HCR: begin
        next_rdata[31:HCR_CNT_LSB] = pending_deactivate_count;
        next_rdata[HCR_DEACTIVATE_WRITE_TRAP] = deactivate_write_trap;
        next_rdata[HCR_SYS_ERROR_TRAP] = 1'b0;
        next_rdata[HCR_GRP1_ACCESS_TRAP] = grp1_access_trap;
        next_rdata[HCR_GRP0_ACCESS_TRAP] = grp0_access_trap;
        next_rdata[HCR_TC] = common_reg_trap;
        next_rdata[HCR_G1D] = g1_off_maint_en;
        next_rdata[HCR_G1E] = g1_on_maint_en;
        next_rdata[HCR_G0D] = g0_off_maint_en;
        next_rdata[HCR_G0E] = g0_on_maint_en;
        next_rdata[HCR_NP] = none_pending_maint_en;
        next_rdata[HCR_LRENP] = entry_absent_maint_en;
        next_rdata[HCR_UNDER] = underflow_maint_en;
        next_rdata[HCR_EN] = hyp_enable;
      end
      SEL_VMCR: begin
        next_rdata[VM_PMR_LSB+:8] = guest_prio_mask;
        next_rdata[VM_BP0_LSB+:3] = guest_binpoint_g0;
        next_rdata[VM_BP1_LSB+:3] = guest_binpoint_g1;
        next_rdata[VM_SPLIT] = split_eoi_select;
        next_rdata[VM_ENG1] = guest_g1_enable;
        next_rdata[VM_ENG0] = guest_g0_enable;
      end
      SEL_BP_G0: next_rdata[2:0] = guest_binpoint_g0;
      SEL_BP_G1: next_rdata[2:0] = bp1_view;
      SEL_PMR: next_rdata[7:0] = guest_prio_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
    end else begin
      rdata <= (req.valid && !req.write) ? next_rdata : rdata;
      rvalid <= req.valid && !req.write;
    end
  end

  // Trap decision and behaviour controls
  always_comb begin
    ctl.trap = guest.valid && guest.guest_ns_kernel &&
      ((deactivate_write_trap && guest.deact_reg && guest.is_write) ||
       (grp1_access_trap && guest.grp1_reg) ||
       (grp0_access_trap && guest.grp0_reg) ||
       (common_reg_trap && guest.common_reg));
    ctl.eoi_deactivates = !split_eoi_select;
    ctl.deact_reg_active = split_eoi_select;
    ctl.preempt_bp_g0 = guest_binpoint_g0;
    ctl.preempt_bp_g1 = shared_binpoint_select ? guest_binpoint_g0 : guest_binpoint_g1;
  end

  // Maintenance interrupt level
  always_comb begin
    maint_irq = hyp_enable && (
      (g1_off_maint_en && !guest_g1_enable) || (g1_on_maint_en && guest_g1_enable) ||
      (g0_off_maint_en && !guest_g0_enable) || (g0_on_maint_en && guest_g0_enable) ||
      (none_pending_maint_en && (lr_pending == '0)) ||
      (entry_absent_maint_en && (pending_deactivate_count != 5'h00)) ||
      (underflow_maint_en && ($countones(lr_valid) <= 1)));
  end
endmodule

// ### tb/vichc_lr_model.sv
// Purpose: List register status and deactivation events seen by the hyp control block
// Assumes: Driven on falling edges; the bench calls the tasks
// Notes: Events are single-cycle pulses
`timescale 1ns/10ps
module vichc_lr_model (
  // Clock
  input wire logic mclk,
  // List register status
  output logic [vichc_pkg::NUM_LR-1:0] lr_pending,
  output logic [vichc_pkg::NUM_LR-1:0] lr_valid,
  // Deactivation bookkeeping
  output logic eoi_no_entry,
  output logic deact_done
);
  import vichc_pkg::*;
  initial begin
    lr_pending = 4'h0;
    lr_valid = 4'h0;
    eoi_no_entry = 1'b0;
    deact_done = 1'b0;
  end
  task automatic set_lr(input logic [3:0] p, input logic [3:0] v);
    @(negedge mclk);
    lr_pending = p;
    lr_valid = v;
  endtask
  // One event per call, never both at once
  task automatic pulse(input logic eoi);
    @(negedge mclk);
    eoi_no_entry = eoi;
    deact_done = !eoi;
    @(negedge mclk);
    eoi_no_entry = 1'b0;
    deact_done = 1'b0;
  endtask
endmodule

// ### tb/vichc_checker.sv
// Purpose: Port-level checks of the hyp control block
// Assumes: Register writes land on the request edge
// Notes: Bound to vichc_top
`timescale 1ns/10ps
module vichc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire vichc_pkg::vichc_req_s req,
  input wire logic [31:0] rdata,
  // Status
  input wire vichc_pkg::vichc_ctl_s ctl,
  input wire logic [vichc_pkg::NUM_LR-1:0] lr_pending,
  input wire logic [vichc_pkg::NUM_LR-1:0] lr_valid,
  input wire logic eoi_no_entry,
  input wire logic deact_done,
  input wire logic maint_irq
);
  import vichc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic hcr_wr;
  assign hcr_wr = req.valid && req.write && req.sel == SEL_HCR;
  split_excl_a: assert property (ctl.eoi_deactivates != ctl.deact_reg_active)
    else $error("split mode outputs disagree");
  shared_bp_a: assert property (req.valid && req.write && req.sel == SEL_VIF_CTRL && req.wdata[0]
    |=> ctl.preempt_bp_g1 == ctl.preempt_bp_g0) else $error("shared binary point not applied");
  hcr_zero_a: assert property (req.valid && !req.write && req.sel == SEL_HCR
    |=> rdata[26:15] == 12'h0 && rdata[13] == 1'b0 && rdata[9:8] == 2'h0) else $error("fixed zero bits read set");
  bp_floor_a: assert property (req.valid && req.write && req.sel == SEL_BP_G0 && req.wdata[2:0] < BP0_MIN
    |=> ctl.preempt_bp_g0 == BP0_MIN) else $error("group 0 binary point below floor");
  vm_alias_a: assert property (req.valid && req.write && req.sel == SEL_VMCR && req.wdata[23:21] >= BP0_MIN
    |=> ctl.preempt_bp_g0 == $past(req.wdata[23:21])) else $error("vm view binary point not aliased");
  gate_off_a: assert property (hcr_wr && !req.wdata[0] |=> !maint_irq)
    else $error("maintenance while interface disabled");
  under_irq_a: assert property (hcr_wr && req.wdata[1:0] == 2'h3 ##1 $countones(lr_valid) <= 1
    |-> maint_irq) else $error("underflow maintenance missing");
  none_pend_a: assert property (hcr_wr && req.wdata[3] && req.wdata[0] ##1 lr_pending == 4'h0
    |-> maint_irq) else $error("no-pending maintenance missing");
  count_irq_a: assert property (hcr_wr && req.wdata[2] && req.wdata[0] && req.wdata[31:27] != 5'h0
    && !eoi_no_entry && !deact_done |=> maint_irq) else $error("count maintenance missing");
endmodule
bind vichc_top vichc_checker u_vichc_checker (.mclk, .rst, .req, .rdata, .ctl, .lr_pending, .lr_valid,
  .eoi_no_entry, .deact_done, .maint_irq);

// ### tb/vichc_top_tb.sv
// Purpose: Self-checking bench for the hyp control block
// Assumes: Inputs change on the falling edge of mclk
// Notes: List register side comes from vichc_lr_model
`timescale 1ns/10ps
module vichc_top_tb;
  import vichc_pkg::*;
  logic mclk;
  logic rst;
  vichc_req_s req;
  vichc_guest_s guest;
  vichc_ctl_s ctl;
  logic [31:0] rdata;
  logic rvalid;
  logic [NUM_LR-1:0] lr_pending;
  logic [NUM_LR-1:0] lr_valid;
  logic eoi_no_entry;
  logic deact_done;
  logic maint_irq;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rst_exp [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h004c_0000, 32'h2, 32'h3, 32'h0, 32'h0};
  int hcr_bit [4] = '{14, 12, 11, 10};
  logic [3:0] cls [4] = '{4'h1, 4'h4, 4'h8, 4'h2};
  vichc_top u_vichc_top (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .guest(guest),
    .ctl(ctl), .lr_pending(lr_pending), .lr_valid(lr_valid), .eoi_no_entry(eoi_no_entry),
    .deact_done(deact_done), .maint_irq(maint_irq));
  vichc_lr_model u_vichc_lr_model (.mclk(mclk), .lr_pending(lr_pending), .lr_valid(lr_valid),
    .eoi_no_entry(eoi_no_entry), .deact_done(deact_done));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(negedge mclk);
    req = '{1'b1, 1'b1, s, d};
    @(negedge mclk);
    req.valid = 1'b0;
  endtask
  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    @(negedge mclk);
    req = '{1'b1, 1'b0, s, 32'h0};
    @(negedge mclk);
    req.valid = 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", e, rdata);
  endtask
  task automatic ckm(input logic e);
    #1;
    chk("maint_irq", {31'h0, e}, {31'h0, maint_irq});
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    guest = '0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(i[3:0], rst_exp[i]);
    end
    wr(SEL_AP_G0, 32'h8000_0001);
    rd(SEL_AP_G0, 32'h8000_0001);
    wr(SEL_AP_G1, 32'h0000_0002);
    rd(SEL_AP_G1, 32'h0000_0002);
    wr(SEL_HCR, 32'hffff_ffff);
    rd(SEL_HCR, 32'hf800_5cff);
    // Deactivate accesses only while split mode is on
    wr(SEL_VIF_CTRL, 32'h2);
    // Each trap bit alone, then a read, a non-kernel access, then cleared
    for (int i = 0; i < 4; i++) begin
      guest = {3'h7, cls[i]};
      wr(SEL_HCR, 32'h1 << hcr_bit[i]);
      chk("trap", 32'h1, {31'h0, ctl.trap});
      guest.is_write = 1'b0;
      #1;
      chk("trap", {31'h0, (i != 0)}, {31'h0, ctl.trap});
      guest.is_write = 1'b1;
      guest.guest_ns_kernel = 1'b0;
      #1;
      chk("trap", 32'h0, {31'h0, ctl.trap});
      guest.guest_ns_kernel = 1'b1;
      wr(SEL_HCR, 32'h0);
      chk("trap", 32'h0, {31'h0, ctl.trap});
    end
    guest = '0;
    wr(SEL_VIF_CTRL, 32'h0);
    chk("eoi_deactivates", 32'h1, {31'h0, ctl.eoi_deactivates});
    chk("deact_reg_active", 32'h0, {31'h0, ctl.deact_reg_active});
    for (int i = 0; i < 4; i++) begin
      for (int e = 0; e < 2; e++) begin
        wr(SEL_VMCR, {30'h0, e[0], e[0]});
        wr(SEL_HCR, 32'h1 | (32'h1 << (7 - i)));
        ckm((i % 2) == e);
      end
    end
    wr(SEL_HCR, 32'h40);
    ckm(1'b0);
    wr(SEL_HCR, 32'h9);
    u_vichc_lr_model.set_lr(4'h0, 4'hf);
    ckm(1'b1);
    u_vichc_lr_model.set_lr(4'h1, 4'hf);
    ckm(1'b0);
    wr(SEL_HCR, 32'h3);
    u_vichc_lr_model.set_lr(4'hf, 4'h1);
    ckm(1'b1);
    u_vichc_lr_model.set_lr(4'hf, 4'h3);
    ckm(1'b0);
    u_vichc_lr_model.set_lr(4'hf, 4'h0);
    ckm(1'b1);
    u_vichc_lr_model.set_lr(4'hf, 4'hf);
    wr(SEL_HCR, 32'h5);
    u_vichc_lr_model.pulse(1'b1);
    u_vichc_lr_model.pulse(1'b1);
    rd(SEL_HCR, 32'h1000_0005);
    ckm(1'b1);
    repeat (3) u_vichc_lr_model.pulse(1'b0);
    rd(SEL_HCR, 32'h0000_0005);
    ckm(1'b0);
    // Count event and count write in one cycle: the event wins
    fork
      wr(SEL_HCR, 32'h5000_0005);
      u_vichc_lr_model.pulse(1'b1);
    join
    rd(SEL_HCR, 32'h0800_0005);
    ckm(1'b1);
    wr(SEL_VIF_CTRL, 32'h2);
    chk("eoi_deactivates", 32'h0, {31'h0, ctl.eoi_deactivates});
    chk("deact_reg_active", 32'h1, {31'h0, ctl.deact_reg_active});
    rd(SEL_VMCR, 32'h004c_0203);
    wr(SEL_VMCR, 32'h0);
    rd(SEL_VIF_CTRL, 32'h0);
    wr(SEL_BP_G0, 32'h4);
    wr(SEL_VIF_CTRL, 32'h1);
    rd(SEL_BP_G1, 32'h5);
    chk("preempt_bp_g1", 32'h4, {29'h0, ctl.preempt_bp_g1});
    chk("preempt_bp_g0", 32'h4, {29'h0, ctl.preempt_bp_g0});
    wr(SEL_BP_G1, 32'h7);
    wr(SEL_BP_G0, 32'h7);
    rd(SEL_BP_G1, 32'h7);
    wr(SEL_VIF_CTRL, 32'h0);
    rd(SEL_BP_G1, 32'h3);
    chk("preempt_bp_g1", 32'h3, {29'h0, ctl.preempt_bp_g1});
    wr(SEL_BP_G0, 32'h0);
    rd(SEL_BP_G0, 32'h2);
    wr(SEL_BP_G1, 32'h1);
    rd(SEL_BP_G1, 32'h3);
    wr(SEL_BP_G0, 32'hffff_fff5);
    rd(SEL_BP_G0, 32'h5);
    wr(SEL_VMCR, 32'ha5b8_0000);
    rd(SEL_PMR, 32'ha5);
    rd(SEL_BP_G0, 32'h5);
    rd(SEL_BP_G1, 32'h6);
    wr(SEL_PMR, 32'h3c);
    rd(SEL_VMCR, 32'h3cb8_0000);
    // Reset in mid-run: maint_irq low, SEL_AP_G0, SEL_HCR and SEL_VMCR read back their reset values
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    ckm(1'b0);
    rd(SEL_AP_G0, 32'h0);
    rd(SEL_HCR, 32'h0);
    rd(SEL_VMCR, 32'h004c_0000);
    end_of_test();
  end
endmodule
